// File: hdl/asp_ports.sv
// Top level of the two address-shared pin ports with their register port.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "asp_params.svh"
// Contract
// R1: Low port has writable 8-bit direction register.
// R2: Modes 1-4: low direction forced ones, address.
// R3: Modes 5-6: direction picks address out or input.
// R4: Mode 7: low port is general I/O.
// R5: Modes 5-7: direction register reads all ones.
// R6: Direction cleared by reset, hardware standby.
// R7: Software standby keeps driving enabled outputs.
// R8: Data read: pin when input, latch otherwise.
// R9: Data latch cleared by reset, hardware standby.
// R10: Registers decoded on low sixteen address bits.
// R11: Modes 1-4: high port drives A15..A8.
// R12: Modes 5-6: high direction picks address or input.
// R13: Mode 7: high port pure general I/O.
// R14: DRAM area 3: A9, A8 carry row/column.
// R15: Modes 1-4: low port drives A7..A0.
// R16: Address pins drive bus controller address.
module asp_ports
  import asp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] mode_sel,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [23:0] bus_addr,
  input wire logic [7:0] low_pin_in,
  input wire logic [7:0] high_pin_in,
  output logic [7:0] low_pin_out,
  output logic [7:0] low_pin_oe,
  output logic [7:0] high_pin_out,
  output logic [7:0] high_pin_oe
);
  // Reset release stages.
  logic rst_meta_reg;
  logic rst_sync_reg;
  // Registered mode and standby levels.
  logic [2:0] mode_meta_reg;
  logic [2:0] mode_reg;
  logic hws_meta_reg;
  logic hws_reg;
  logic sws_meta_reg;
  logic sws_reg;
  // Synchronised pin levels.
  asp_byte_t low_pin_sync;
  asp_byte_t high_pin_sync;
  // Decoded function class.
  asp_fn_t fn;
  // Register decode strobes.
  wire hit_low_dir = reg_addr == `ASP_LOW_DIR_ADDR;
  wire hit_low_data = reg_addr == `ASP_LOW_DATA_ADDR;
  wire hit_high_dir = reg_addr == `ASP_HIGH_DIR_ADDR;
  wire hit_high_data = reg_addr == `ASP_HIGH_DATA_ADDR;
  // Next value of the read data register.
  asp_byte_t reg_rdata_next;
  // Next pin drive values, frozen during software standby.
  asp_byte_t low_out_next;
  asp_byte_t high_out_next;

  asp_port_if low_if();
  asp_port_if high_if();

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // Mode and standby pins come from outside and pass two stages.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      mode_meta_reg <= `ASP_MODE_7;
      mode_reg <= `ASP_MODE_7;
      hws_meta_reg <= 1'b0;
      hws_reg <= 1'b0;
      sws_meta_reg <= 1'b0;
      sws_reg <= 1'b0;
    end else begin
      mode_meta_reg <= mode_sel;
      mode_reg <= mode_meta_reg;
      hws_meta_reg <= hw_standby;
      hws_reg <= hws_meta_reg;
      sws_meta_reg <= sw_standby;
      sws_reg <= sws_meta_reg;
    end
  end

  asp_sync #(.WIDTH(`ASP_PORT_W)) u_low_sync (
    .mclk(mclk),
    .rst_sync_n(rst_sync_reg),
    .async_in(low_pin_in),
    .sync_out(low_pin_sync)
  );

  asp_sync #(.WIDTH(`ASP_PORT_W)) u_high_sync (
    .mclk(mclk),
    .rst_sync_n(rst_sync_reg),
    .async_in(high_pin_in),
    .sync_out(high_pin_sync)
  );

  // Mode 1..4 address only, 5..6 address or input, 7 general I/O; 0 treated as 7.
  assign fn = (mode_reg >= `ASP_MODE_1 && mode_reg <= `ASP_MODE_4) ? ASP_FN_ADDR_ONLY : // [R2] [R11]
              (mode_reg == `ASP_MODE_7 || mode_reg == `ASP_MODE_0) ? ASP_FN_GPIO : // [R4] [R13]
              ASP_FN_ADDR_OR_IN; // [R3] [R12]

  // Low port wiring; address bits 7..0 come from the bus controller.
  assign low_if.fn = fn;
  assign low_if.dir_we = reg_wr && hit_low_dir; // [R1] [R10]
  assign low_if.data_we = reg_wr && hit_low_data; // [R10]
  assign low_if.wdata = reg_wdata;
  assign low_if.hw_standby = hws_reg; // [R6] [R9]
  assign low_if.addr_byte = bus_addr[`ASP_LOW_BYTE_LSB +: 8]; // [R15] [R16]
  assign low_if.pin_sync = low_pin_sync;

  // High port wiring; bits 9 and 8 carry the DRAM row or column as supplied.
  assign high_if.fn = fn;
  assign high_if.dir_we = reg_wr && hit_high_dir;
  assign high_if.data_we = reg_wr && hit_high_data;
  assign high_if.wdata = reg_wdata;
  assign high_if.hw_standby = hws_reg;
  assign high_if.addr_byte = bus_addr[`ASP_HIGH_BYTE_LSB +: 8]; // [R14] [R16]
  assign high_if.pin_sync = high_pin_sync;

  asp_port_slice u_low (
    .mclk(mclk),
    .rst_sync_n(rst_sync_reg),
    .pif(low_if)
  );

  asp_port_slice u_high (
    .mclk(mclk),
    .rst_sync_n(rst_sync_reg),
    .pif(high_if)
  );

  // Read mux; direction registers always read ones, unmapped reads zero.
  assign reg_rdata_next = !reg_rd ? `ASP_ALL_ZERO :
                          hit_low_dir ? low_if.dir_read : // [R5]
                          hit_low_data ? low_if.data_read : // [R8]
                          hit_high_dir ? high_if.dir_read :
                          hit_high_data ? high_if.data_read :
                          `ASP_ALL_ZERO;

  // Software standby freezes the driven values of enabled outputs.
  assign low_out_next = sws_reg ? low_pin_out : low_if.pin_out; // [R7]
  assign high_out_next = sws_reg ? high_pin_out : high_if.pin_out; // [R7]

  // Read data register, valid only in the cycle after the read strobe.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      reg_rdata <= `ASP_ALL_ZERO;
    end else begin
      reg_rdata <= reg_rdata_next;
    end
  end

  // Pin drive registers.
  always_ff @(posedge mclk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      low_pin_out <= `ASP_ALL_ZERO;
      low_pin_oe <= `ASP_ALL_ZERO;
      high_pin_out <= `ASP_ALL_ZERO;
      high_pin_oe <= `ASP_ALL_ZERO;
    end else begin
      low_pin_out <= low_out_next;
      low_pin_oe <= low_if.pin_oe; // [R2] [R3] [R4]
      high_pin_out <= high_out_next;
      high_pin_oe <= high_if.pin_oe; // [R11] [R12] [R13]
    end
  end
endmodule

// File: include/asp_params.svh
// Address map, reset values, mode codes and field sizes for the address-shared pin ports.
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH
`define ASP_ADDR_W 16
`define ASP_PORT_W 8
`define ASP_LOW_DIR_ADDR 16'hFFC0
`define ASP_LOW_DATA_ADDR 16'hFFC2
`define ASP_HIGH_DIR_ADDR 16'hFFC1
`define ASP_HIGH_DATA_ADDR 16'hFFC3
`define ASP_DIR_RESET 8'h00
`define ASP_DATA_RESET 8'h00
`define ASP_ALL_ONES 8'hFF
`define ASP_ALL_ZERO 8'h00
`define ASP_MODE_W 3
`define ASP_MODE_4 3'h4
`define ASP_MODE_7 3'h7
`define ASP_MODE_1 3'h1
`define ASP_MODE_0 3'h0
`define ASP_BUS_ADDR_W 24
`define ASP_LOW_BYTE_LSB 0
`define ASP_HIGH_BYTE_LSB 8
`endif

// File: include/asp_pkg.sv
// Types shared by the address-shared pin port design.
package asp_pkg;
  // Pin function class chosen by the operating mode.
  typedef enum logic [1:0] {
    ASP_FN_ADDR_ONLY,
    ASP_FN_ADDR_OR_IN,
    ASP_FN_GPIO
  } asp_fn_t;
  // Byte wide port value.
  typedef logic [7:0] asp_byte_t;
endpackage

// File: include/asp_port_if.sv
// Carrier between the top level and each port slice.
`timescale 1ns/1ps
interface asp_port_if;
  import asp_pkg::*;
  // Decoded function class of the current mode.
  asp_fn_t fn;
  // Write strobes for the direction and data registers.
  logic dir_we;
  logic data_we;
  // Write data from the bus.
  asp_byte_t wdata;
  // Hardware standby indication.
  logic hw_standby;
  // Bus controller address byte for this port.
  asp_byte_t addr_byte;
  // Synchronised pin levels.
  asp_byte_t pin_sync;
  // Results from the slice.
  asp_byte_t dir_read;
  asp_byte_t data_read;
  asp_byte_t pin_out;
  asp_byte_t pin_oe;
  modport top (output fn, dir_we, data_we, wdata, hw_standby, addr_byte, pin_sync,
               input dir_read, data_read, pin_out, pin_oe);
  modport slice (input fn, dir_we, data_we, wdata, hw_standby, addr_byte, pin_sync,
                 output dir_read, data_read, pin_out, pin_oe);
endinterface

// File: hdl/asp_port_slice.sv
// One 8-bit port: direction and data registers, read-back and pin drive.
`timescale 1ns/1ps
`include "asp_params.svh"
module asp_port_slice
  import asp_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_sync_n,
  asp_port_if.slice pif
);
  // Software-written direction register.
  asp_byte_t dir_reg;
  // Software-written output latch.
  asp_byte_t data_reg;
  // Direction seen by the pins: forced to outputs in address-only modes.
  asp_byte_t dir_eff;
  // Value presented to each output pin.
  asp_byte_t drive_val;

  assign dir_eff = (pif.fn == ASP_FN_ADDR_ONLY) ? `ASP_ALL_ONES : dir_reg;
  // Address function pins carry the bus controller byte, gpio pins carry the latch.
  assign drive_val = (pif.fn == ASP_FN_GPIO) ? data_reg : pif.addr_byte;
  // Direction register never reads back; all ones are returned.
  assign pif.dir_read = `ASP_ALL_ONES;
  // Input bits read the pin, output bits read the latch.
  assign pif.data_read = (dir_eff & data_reg) | (~dir_eff & pif.pin_sync);
  assign pif.pin_out = drive_val;
  assign pif.pin_oe = dir_eff;

  // Direction register: cleared by reset and hardware standby, written only outside address-only modes, held otherwise.
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      dir_reg <= `ASP_DIR_RESET;
    end else if (pif.hw_standby) begin
      dir_reg <= `ASP_DIR_RESET;
    end else if (pif.dir_we && pif.fn != ASP_FN_ADDR_ONLY) begin
      dir_reg <= pif.wdata;
    end
  end

  // Output latch: cleared by reset and hardware standby, kept in software standby.
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      data_reg <= `ASP_DATA_RESET;
    end else if (pif.hw_standby) begin
      data_reg <= `ASP_DATA_RESET;
    end else if (pif.data_we) begin
      data_reg <= pif.wdata;
    end
  end
endmodule

// File: hdl/asp_sync.sv
// Two flip-flop synchroniser for a vector of pin levels.
`timescale 1ns/1ps
module asp_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic rst_sync_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  // First stage, read only by the second stage.
  logic [WIDTH-1:0] meta_reg;

  // Two stage capture of the asynchronous levels.
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// File: sim/asp_ports_properties.sv
// Concurrent checks on the pin and register ports of the address-shared pin ports.
`timescale 1ns/1ps
module asp_ports_properties (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [2:0] mode_sel,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [23:0] bus_addr,
  input wire logic [7:0] low_pin_out,
  input wire logic [7:0] low_pin_oe,
  input wire logic [7:0] high_pin_out,
  input wire logic [7:0] high_pin_oe
);
  // All checks share the one clock and the raw reset.
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // High in the expanded modes without on-chip memory.
  wire mode_exp = mode_sel inside {[3'h1:3'h4]};
  // High in the expanded modes with selectable address pins.
  wire mode_mix = mode_sel inside {3'h5, 3'h6};
  // Read data must be zero outside the cycle after a read strobe.
  AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  AST_DIR_ONES: assert property ($past(reg_rd) && $past(reg_addr) == 16'hFFC0 |-> reg_rdata == 8'hFF)
    else $error("direction read did not return all ones");
  AST_UNMAPPED: assert property ($past(reg_rd) && !($past(reg_addr) inside {[16'hFFC0:16'hFFC3]})
    |-> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  AST_EXP_OE: assert property (mode_exp [*8] |-> low_pin_oe == 8'hFF && high_pin_oe == 8'hFF)
    else $error("address pins not all driven");
  AST_LOW_ADDR: assert property ((mode_exp && !sw_standby) [*8] |-> low_pin_out == $past(bus_addr[7:0]))
    else $error("low port not showing low address byte");
  AST_HIGH_ADDR: assert property ((mode_exp && !sw_standby) [*8]
    |-> high_pin_out == $past(bus_addr[15:8]))
    else $error("high port not showing upper address byte");
  AST_MIX_ADDR: assert property ((mode_mix && !sw_standby) [*8] |-> low_pin_out == $past(bus_addr[7:0])
    && high_pin_out == $past(bus_addr[15:8]))
    else $error("address pins not following bus address");
  AST_SW_HOLD: assert property (sw_standby [*5] |-> $stable(low_pin_out) && $stable(high_pin_out))
    else $error("pin drive changed in software standby");
  AST_HW_CLEAR: assert property ((hw_standby && mode_sel >= 3'h5) [*6]
    |-> low_pin_oe == 8'h00 && high_pin_oe == 8'h00)
    else $error("pins still driven in hardware standby");
endmodule
bind asp_ports asp_ports_properties i_asp_ports_properties (.mclk, .rst_n, .mode_sel, .hw_standby,
  .sw_standby, .reg_addr, .reg_rd, .reg_rdata, .bus_addr, .low_pin_out, .low_pin_oe, .high_pin_out, .high_pin_oe);

// File: sim/asp_pin_model.sv
// Far-side model of the devices sharing one 8-bit pin port.
`timescale 1ns/1ps
module asp_pin_model (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] ext_drive,
  output logic [7:0] pin_level
);
  // A pin shows the port's drive where enabled, else the external device's level.
  assign pin_level = (pin_out & pin_oe) | (ext_drive & ~pin_oe);
endmodule

// File: sim/test_asp_ports.sv
// Self-checking bench for the address-shared pin ports.
`timescale 1ns/1ps
module test_asp_ports;
  import asp_pkg::*;
  // Stimulus, observed outputs and counters.
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] mode_sel = 3'h7;
  logic hw_standby = 1'b0;
  logic sw_standby = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  asp_byte_t reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [23:0] bus_addr = 24'h000000;
  asp_byte_t reg_rdata, lo_out, lo_oe, hi_out, hi_oe, lo_in, hi_in;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  asp_ports i_asp_ports (.mclk(mclk), .rst_n(rst_n), .mode_sel(mode_sel), .hw_standby(hw_standby),
    .sw_standby(sw_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_addr(bus_addr), .low_pin_in(lo_in), .high_pin_in(hi_in),
    .low_pin_out(lo_out), .low_pin_oe(lo_oe), .high_pin_out(hi_out), .high_pin_oe(hi_oe));
  asp_pin_model i_lo_pins (.pin_out(lo_out), .pin_oe(lo_oe), .ext_drive(8'hA5), .pin_level(lo_in));
  asp_pin_model i_hi_pins (.pin_out(hi_out), .pin_oe(hi_oe), .ext_drive(8'h96), .pin_level(hi_in));
  // The 50 MHz clock.
  initial begin
    forever #10 mclk = ~mclk;
  end
  // Ends the run with the counts and the verdict.
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Cuts a hung run short.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      results();
    end
  end
  // Compares one byte result.
  task automatic chk(input asp_byte_t got, input asp_byte_t exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Waits n edges and steps off the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // One-cycle register write.
  task automatic wr(input logic [15:0] a, input asp_byte_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle register read; data is taken in the following cycle.
  task automatic rd(input logic [15:0] a, input asp_byte_t e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // Lets pin drive settle, then checks enables and levels of both ports.
  task automatic pins(input asp_byte_t lo, input asp_byte_t lv, input asp_byte_t hi, input asp_byte_t hv);
    cyc(4);
    chk(lo_oe, lo);
    chk(lo_out, lv);
    chk(hi_oe, hi);
    chk(hi_out, hv);
  endtask
  // Main sequence.
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    cyc(6);
    rd(16'hFFC0, 8'hFF);
    rd(16'hFFC2, 8'hA5);
    wr(16'hFFC0, 8'hFF);
    rd(16'hFFC2, 8'h00);
    wr(16'hFFC2, 8'h3C);
    wr(16'hFFC1, 8'hFF);
    wr(16'hFFC3, 8'h5A);
    pins(8'hFF, 8'h3C, 8'hFF, 8'h5A);
    wr(16'hFFC0, 8'h0F);
    // Released pins reach the data read only after the drive register and two sync stages.
    cyc(3);
    rd(16'hFFC2, 8'hAC);
    $display("test single chip done");
    @(posedge mclk);
    sw_standby <= 1'b1;
    cyc(5);
    wr(16'hFFC2, 8'hC3);
    pins(8'h0F, 8'h3C, 8'hFF, 8'h5A);
    @(posedge mclk);
    sw_standby <= 1'b0;
    pins(8'h0F, 8'hC3, 8'hFF, 8'h5A);
    $display("test software standby done");
    @(posedge mclk);
    hw_standby <= 1'b1;
    cyc(6);
    @(posedge mclk);
    hw_standby <= 1'b0;
    pins(8'h00, 8'h00, 8'h00, 8'h00);
    rd(16'hFFC2, 8'hA5);
    $display("test hardware standby done");
    @(posedge mclk);
    mode_sel <= 3'h5;
    bus_addr <= 24'h34C3E1;
    wr(16'hFFC0, 8'hF0);
    wr(16'hFFC1, 8'h0F);
    pins(8'hF0, 8'hE1, 8'h0F, 8'hC3);
    @(posedge mclk);
    mode_sel <= 3'h6;
    pins(8'hF0, 8'hE1, 8'h0F, 8'hC3);
    rd(16'hFFC0, 8'hFF);
    $display("test mixed modes done");
    for (int m = 1; m < 5; m++) begin
      @(posedge mclk);
      mode_sel <= m[2:0];
      bus_addr <= 24'h00FF00 ^ 24'(m * 17);
      wr(16'hFFC0, 8'h00);
      pins(8'hFF, bus_addr[7:0], 8'hFF, bus_addr[15:8]);
    end
    rd(16'hFFC2, 8'h00);
    // Direction writes in an address-only mode must leave the stored directions alone.
    wr(16'hFFC0, 8'hFF);
    wr(16'hFFC1, 8'hFF);
    @(posedge mclk);
    mode_sel <= 3'h5;
    pins(8'h00, bus_addr[7:0], 8'h0F, bus_addr[15:8]);
    // Mode code zero behaves as the single-chip mode.
    @(posedge mclk);
    mode_sel <= 3'h0;
    pins(8'h00, 8'h00, 8'h0F, 8'h00);
    $display("test expanded modes done");
    rd(16'hFFC4, 8'h00);
    rd(16'h7FC2, 8'h00);
    $display("test address decode done");
    results();
  end
endmodule
